// file: design/bsd_map.svh
// Constants of the branch and system-control decoder
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH
// Number of control registers and their selector width
`define BSD_NUM_CREG 4
`define BSD_CREG_SEL_W 2
// Control register selectors
`define BSD_CREG_STATUS 2'h0
`define BSD_CREG_GLOBAL 2'h1
`define BSD_CREG_VECTOR 2'h2
// Position of the condition flag inside the status word
`define BSD_T_BIT 0
// Reset values
`define BSD_T_RESET 1'b0
`define BSD_CREG_RESET 32'h0000_0000
// Step from an instruction to the next one, in bytes
`define BSD_PC_STEP 32'h0000_0004
// Operand sizes: byte, word, long
`define BSD_SIZE_BYTE 2'h0
`define BSD_SIZE_WORD 2'h1
`define BSD_SIZE_LONG 2'h2
// Extra execution states for load-use and fetch/data contention
`define BSD_LOAD_USE_STATES 1
`define BSD_CONTENTION_STATES 1
`endif

// file: design/bsd_pkg.sv
// Types shared by the branch and system-control decoder
package bsd_pkg;
    // Instruction classes handed to the decoder
    typedef enum logic [3:0] {
        OP_NONE, OP_BF, OP_BFS, OP_BT, OP_BTS, OP_BSR, OP_RTS,
        OP_RTE, OP_SLEEP, OP_LDC, OP_STC, OP_SETT, OP_CLRT,
        OP_LOAD, OP_ALU
    } bsd_op_type;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN, ST_WAIT, ST_EXEC, ST_SLEEP
    } bsd_state_type;
endpackage

// file: design/bsd_disp_scale.sv
// Displacement scaling by operand size
`timescale 1ns/1ps
`include "bsd_map.svh"
module bsd_disp_scale (
    // Raw displacement field
    input wire logic [7:0] i_disp,
    input wire logic i_sext,
    input wire logic [1:0] i_size,
    // Scaled displacement
    output logic [31:0] o_scaled
);
    // Widen the field, signed or unsigned, before scaling
    function automatic logic [31:0] widen(input logic [7:0] d,
                                          input logic s);
        widen = {{24{s & d[7]}}, d};
    endfunction

    // Widened field; a function result cannot be part-selected directly
    logic [31:0] wide;
    assign wide = widen(i_disp, i_sext);

    ////////////////////////////////////////////////////////////////
    // Multiply by one, two or four; other codes fall back to one
    always_comb begin
        case (i_size)
            `BSD_SIZE_WORD: o_scaled = {wide[30:0], 1'b0};
            `BSD_SIZE_LONG: o_scaled = {wide[29:0], 2'h0};
            default: o_scaled = wide;
        endcase
    end
endmodule

// file: design/bsd_decode.sv
// Branch and system-control instruction sequencer
//
// What this block does
// - branch-if-false taken only when flag 0
// - branch-if-true taken only when flag 1
// - subroutine return resumes at saved point
// - exception return resumes interrupted flow
// - sleep enters power-down state
// - load control register writes selected register
// - store control register returns its contents
// - flag defined after each; else unchanged
// - displacement scaled by one, two, four
// - load-use dependency adds execution states
// - fetch/data contention adds execution states
`timescale 1ns/1ps
`include "bsd_map.svh"
module bsd_decode
    import bsd_pkg::*;
#(
    parameter int LOAD_USE_STATES = `BSD_LOAD_USE_STATES,
    parameter int CONTENTION_STATES = `BSD_CONTENTION_STATES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Instruction offered by the fetch stage
    input wire logic i_valid,
    input wire bsd_op_type i_op,
    input wire logic [31:0] i_pc,
    input wire logic [7:0] i_disp,
    input wire logic i_disp_sext,
    input wire logic [1:0] i_size,
    input wire logic [3:0] i_dst,
    input wire logic [3:0] i_src_a,
    input wire logic i_src_a_use,
    input wire logic [3:0] i_src_b,
    input wire logic i_src_b_use,
    input wire logic [1:0] i_creg_sel,
    input wire logic [31:0] i_wdata,
    input wire logic i_t_wr,
    input wire logic i_t_new,
    // Bus contention and core events
    input wire logic i_data_access,
    input wire logic i_fetch_busy,
    input wire logic i_exc_enter,
    input wire logic [31:0] i_exc_pc,
    input wire logic i_wake,
    // Sequencer answers
    output logic o_ready,
    output logic o_stall,
    output logic o_branch,
    output logic [31:0] o_target,
    output logic o_sleep,
    output logic o_in_exc,
    output logic o_t_flag,
    output logic [31:0] o_result,
    output logic o_result_valid
);
    // Every piece of state of the sequencer
    typedef struct packed {
        bsd_state_type state;
        logic ready;
        logic stall;
        logic [3:0] cnt;
        bsd_op_type op;
        logic [31:0] pc;
        logic [31:0] disp;
        logic [1:0] sel;
        logic [31:0] wdata;
        logic t_wr;
        logic t_new;
        logic [3:0] dst;
        logic [3:0] load_dst;
        logic load_live;
        logic slot_pend;
        logic [31:0] slot_tgt;
        logic [31:0] ret_pc;
        logic [31:0] exc_pc;
        logic exc_t;
        logic in_exc;
        logic t;
        logic [`BSD_NUM_CREG-1:0][31:0] creg;
        logic branch;
        logic [31:0] target;
        logic sleep;
        logic [31:0] result;
        logic result_valid;
    } bsd_regs_type;

    bsd_regs_type r; // Registered state
    bsd_regs_type next_r; // Next state
    logic [31:0] scaled; // Displacement after scaling
    logic accept; // Instruction taken this cycle
    logic hazard; // Operand depends on the previous load
    logic contend; // Fetch and data access collide

    // Counter is four bits and two extra counts add up
    if (LOAD_USE_STATES < 0 || LOAD_USE_STATES > 7 ||
        CONTENTION_STATES < 0 || CONTENTION_STATES > 7) begin : g_chk
        $error("extra state counts must lie in 0..7");
    end

    ////////////////////////////////////////////////////////////////
    // Displacement scaler
    bsd_disp_scale u_scale (
        .i_disp(i_disp),
        .i_sext(i_disp_sext),
        .i_size(i_size),
        .o_scaled(scaled)
    );

    ////////////////////////////////////////////////////////////////
    // Acceptance and extra-state causes
    assign accept = i_valid & r.ready & ~i_exc_enter;
    assign hazard = r.load_live &
                    ((i_src_a_use & (i_src_a == r.load_dst)) |
                     (i_src_b_use & (i_src_b == r.load_dst)));
    assign contend = i_data_access & i_fetch_busy;

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [3:0] extra;
        logic take;
        extra = 4'h0;
        take = 1'b0;
        next_r = r;
        // Pulses last one cycle
        next_r.branch = 1'b0;
        next_r.result_valid = 1'b0;
        case (r.state)
            ST_RUN: begin
                if (i_exc_enter) begin
                    // Save the flow that the handler interrupts
                    next_r.exc_pc = i_exc_pc;
                    next_r.exc_t = r.t;
                    next_r.in_exc = 1'b1;
                    next_r.slot_pend = 1'b0;
                end else if (accept) begin
                    next_r.op = i_op;
                    next_r.pc = i_pc;
                    next_r.disp = scaled;
                    next_r.sel = i_creg_sel;
                    next_r.wdata = i_wdata;
                    next_r.t_wr = i_t_wr;
                    next_r.t_new = i_t_new;
                    next_r.dst = i_dst;
                    next_r.load_live = 1'b0;
                    // Dependency only matters for the very next one
                    if (hazard) begin
                        extra = 4'(LOAD_USE_STATES);
                    end
                    if (contend) begin
                        extra = extra + 4'(CONTENTION_STATES);
                    end
                    next_r.cnt = extra;
                    next_r.state = (extra != 4'h0) ? ST_WAIT : ST_EXEC;
                end
            end
            ST_WAIT: begin
                // Count down the added states
                next_r.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h1) begin
                    next_r.state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_r.state = ST_RUN;
                case (r.op)
                    OP_BF, OP_BFS: begin
                        take = ~r.t;
                    end
                    OP_BT, OP_BTS: begin
                        take = r.t;
                    end
                    OP_BSR: begin
                        next_r.ret_pc = r.pc + `BSD_PC_STEP;
                        next_r.branch = 1'b1;
                        next_r.target = r.pc + `BSD_PC_STEP + r.disp;
                    end
                    OP_RTS: begin
                        next_r.branch = 1'b1;
                        next_r.target = r.ret_pc;
                    end
                    OP_RTE: begin
                        next_r.branch = 1'b1;
                        next_r.target = r.exc_pc;
                        next_r.t = r.exc_t;
                        next_r.in_exc = 1'b0;
                    end
                    OP_SLEEP: begin
                        next_r.state = ST_SLEEP;
                    end
                    OP_LDC: begin
                        next_r.creg[r.sel] = r.wdata;
                        if (r.sel == `BSD_CREG_STATUS) begin
                            next_r.t = r.wdata[`BSD_T_BIT];
                        end
                    end
                    OP_STC: begin
                        next_r.result = r.creg[r.sel];
                        if (r.sel == `BSD_CREG_STATUS) begin
                            next_r.result[`BSD_T_BIT] = r.t;
                        end
                        next_r.result_valid = 1'b1;
                    end
                    OP_SETT: begin
                        next_r.t = 1'b1;
                    end
                    OP_CLRT: begin
                        next_r.t = 1'b0;
                    end
                    OP_LOAD: begin
                        // Remember the destination for the next check
                        next_r.load_live = 1'b1;
                        next_r.load_dst = r.dst;
                    end
                    OP_ALU: begin
                        if (r.t_wr) begin
                            next_r.t = r.t_new;
                        end
                    end
                    default: begin
                        // Others leave the flag as it was
                    end
                endcase
                if (take) begin
                    if (r.op == OP_BFS || r.op == OP_BTS) begin
                        next_r.slot_pend = 1'b1;
                        next_r.slot_tgt = r.pc + `BSD_PC_STEP + r.disp;
                    end else begin
                        next_r.branch = 1'b1;
                        next_r.target = r.pc + `BSD_PC_STEP + r.disp;
                    end
                end
                // Slot finished: the held target wins over its own
                if (r.slot_pend) begin
                    next_r.slot_pend = 1'b0;
                    next_r.branch = 1'b1;
                    next_r.target = r.slot_tgt;
                end
            end
            ST_SLEEP: begin
                // Stay powered down until woken
                if (i_wake) begin
                    next_r.state = ST_RUN;
                end
            end
            default: begin
                next_r.state = ST_RUN;
            end
        endcase
        next_r.ready = (next_r.state == ST_RUN);
        next_r.stall = (next_r.state == ST_WAIT);
        next_r.sleep = (next_r.state == ST_SLEEP);
    end

    ////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            r <= '0;
            r.state <= ST_RUN;
            r.ready <= 1'b1;
            r.t <= `BSD_T_RESET;
            r.creg <= {`BSD_NUM_CREG{`BSD_CREG_RESET}};
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign o_ready = r.ready;
    assign o_stall = r.stall;
    assign o_branch = r.branch;
    assign o_target = r.target;
    assign o_sleep = r.sleep;
    assign o_in_exc = r.in_exc;
    assign o_t_flag = r.t;
    assign o_result = r.result;
    assign o_result_valid = r.result_valid;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_exec(bsd_op_type op);
        r.state == ST_EXEC && r.op == op && !r.slot_pend;
    endsequence
    sequence s_jump_to(logic [31:0] tgt);
        r.branch && r.target == tgt;
    endsequence

    property p_bf;
        s_exec(OP_BF) |=> (r.branch == !$past(r.t));
    endproperty
    a_bf: assert property (p_bf) else $error("bf wrong");
    property p_bt;
        s_exec(OP_BT) |=> (r.branch == $past(r.t));
    endproperty
    a_bt: assert property (p_bt) else $error("bt wrong");
    property p_rts;
        s_exec(OP_RTS) |=> s_jump_to($past(r.ret_pc));
    endproperty
    a_rts: assert property (p_rts) else $error("rts wrong");
    property p_rte;
        s_exec(OP_RTE) |=> s_jump_to($past(r.exc_pc)) && !r.in_exc;
    endproperty
    a_rte: assert property (p_rte) else $error("rte wrong");
    property p_sleep;
        s_exec(OP_SLEEP) |=> r.sleep && !r.ready;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_ldc;
        s_exec(OP_LDC) |=> r.creg[$past(r.sel)] == $past(r.wdata);
    endproperty
    a_ldc: assert property (p_ldc) else $error("ldc lost");
    property p_stc;
        s_exec(OP_STC) && r.sel != `BSD_CREG_STATUS |=>
            r.result_valid && r.result == $past(r.creg[r.sel]);
    endproperty
    a_stc: assert property (p_stc) else $error("stc wrong");
    property p_t_keep;
        r.state == ST_EXEC && r.op inside {OP_BF, OP_BT, OP_BSR,
            OP_RTS, OP_STC, OP_LOAD} |=> r.t == $past(r.t);
    endproperty
    a_t_keep: assert property (p_t_keep) else $error("t moved");
    property p_scale;
        accept && i_size == `BSD_SIZE_LONG && !i_disp_sext |=>
            r.disp == {22'h0, $past(i_disp), 2'h0};
    endproperty
    a_scale: assert property (p_scale) else $error("bad scale");
    property p_load_use;
        accept && hazard && !contend |=> r.stall [*1] ##1 !r.stall;
    endproperty
    a_load_use: assert property (p_load_use)
        else $error("no load-use state");
    property p_contend;
        accept && contend |=> r.stall && !r.ready;
    endproperty
    a_contend: assert property (p_contend)
        else $error("no contention state");
    sequence s_slot_taken;
        s_exec(OP_BFS) && !r.t;
    endsequence
    property p_slot;
        s_slot_taken |=> !r.branch && r.slot_pend;
    endproperty
    a_slot: assert property (p_slot) else $error("slot skipped");
endmodule

// file: tb/tb_bsd_decode.sv
// Self-checking bench for the branch and system-control sequencer
`timescale 1ns/1ps
module tb_bsd_decode;
    import bsd_pkg::*;
    // Branch table row: flag preset, displacement fields, expected redirect
    typedef struct {
        bsd_op_type op;
        logic t;
        logic [7:0] d;
        logic s;
        logic [1:0] z;
        logic br;
        logic [31:0] off;
    } bsd_row_type;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_valid = 1'b0;
    bsd_op_type i_op = OP_NONE;
    logic [31:0] i_pc = 32'h0, i_wdata = 32'h0, i_exc_pc = 32'h0;
    logic [7:0] i_disp = 8'h0;
    logic [3:0] i_dst = 4'h0, i_src_a = 4'h0, i_src_b = 4'h0;
    logic [1:0] i_size = 2'h0, i_creg_sel = 2'h0;
    logic i_disp_sext = 1'b0, i_src_a_use = 1'b0, i_src_b_use = 1'b0;
    logic i_t_wr = 1'b0, i_t_new = 1'b0, i_data_access = 1'b0;
    logic i_fetch_busy = 1'b0, i_exc_enter = 1'b0, i_wake = 1'b0;
    logic o_ready, o_stall, o_branch, o_sleep, o_in_exc, o_t_flag;
    logic o_result_valid;
    logic [31:0] o_target, o_result;
    // Outcome of the last instruction, gathered while it ran
    logic got_br, got_rv;
    logic [31:0] got_tgt, got_res;
    int stalls, miscompares = 0, tests_run = 0;
    bsd_row_type rows [8] = '{
        '{OP_BF, 1'b0, 8'h03, 1'b0, 2'h0, 1'b1, 32'h0000_0003},
        '{OP_BF, 1'b1, 8'h03, 1'b0, 2'h0, 1'b0, 32'h0000_0000},
        '{OP_BT, 1'b1, 8'h05, 1'b0, 2'h1, 1'b1, 32'h0000_000a},
        '{OP_BT, 1'b0, 8'h05, 1'b0, 2'h1, 1'b0, 32'h0000_0000},
        '{OP_BF, 1'b0, 8'h03, 1'b0, 2'h2, 1'b1, 32'h0000_000c},
        '{OP_BT, 1'b1, 8'hfe, 1'b1, 2'h0, 1'b1, 32'hffff_fffe},
        '{OP_BF, 1'b0, 8'h07, 1'b0, 2'h3, 1'b1, 32'h0000_0007},
        '{OP_BT, 1'b1, 8'h80, 1'b1, 2'h1, 1'b1, 32'hffff_ff00}
    };

    ////////////////////////////////////////////////////////////////////////
    bsd_decode DUT (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
        .i_op(i_op), .i_pc(i_pc), .i_disp(i_disp),
        .i_disp_sext(i_disp_sext), .i_size(i_size), .i_dst(i_dst),
        .i_src_a(i_src_a), .i_src_a_use(i_src_a_use), .i_src_b(i_src_b),
        .i_src_b_use(i_src_b_use), .i_creg_sel(i_creg_sel),
        .i_wdata(i_wdata), .i_t_wr(i_t_wr), .i_t_new(i_t_new),
        .i_data_access(i_data_access), .i_fetch_busy(i_fetch_busy),
        .i_exc_enter(i_exc_enter), .i_exc_pc(i_exc_pc), .i_wake(i_wake),
        .o_ready(o_ready), .o_stall(o_stall), .o_branch(o_branch),
        .o_target(o_target), .o_sleep(o_sleep), .o_in_exc(o_in_exc),
        .o_t_flag(o_t_flag), .o_result(o_result),
        .o_result_valid(o_result_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // 50 ns core clock
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end

    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    // Verdict; both the main sequence and the watchdog end here
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Offer one instruction at a falling edge, then sample every falling
    // edge until ready returns; pulses last a full cycle so none is missed
    task automatic issue(input bsd_op_type op, input logic [31:0] pc);
        int n;
        i_op = op;
        i_pc = pc;
        i_valid = 1'b1;
        got_br = 1'b0;
        got_rv = 1'b0;
        stalls = 0;
        n = 0;
        @(negedge i_core_clk);
        i_valid = 1'b0;
        while (o_ready !== 1'b1 && n < 20) begin
            if (o_stall === 1'b1) stalls++;
            @(negedge i_core_clk);
            n++;
        end
        if (n >= 20) chk("ready return", 32'h1, 32'h0);
        got_br = (o_branch === 1'b1);
        got_tgt = o_target;
        got_rv = (o_result_valid === 1'b1);
        got_res = o_result;
        // Side inputs go back to quiet so the next case starts clean
        {i_src_a_use, i_src_b_use, i_t_wr} = 3'b000;
        {i_data_access, i_fetch_busy} = 2'b00;
    endtask

    // Hung sequencer cuts the run short
    initial begin
        #(4000 * 50);
        miscompares++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        chk("reset ready", 32'h1, {31'h0, o_ready});
        chk("reset flag", 32'h0, {31'h0, o_t_flag});
        chk("reset outs", 32'h0,
            {28'h0, o_sleep, o_in_exc, o_branch, o_stall});
        // Branch table: flag condition and displacement scaling
        foreach (rows[k]) begin
            issue(rows[k].t ? OP_SETT : OP_CLRT, 32'h0);
            chk("preset flag", {31'h0, rows[k].t}, {31'h0, o_t_flag});
            {i_disp, i_disp_sext, i_size} = {rows[k].d, rows[k].s, rows[k].z};
            issue(rows[k].op, 32'h0000_1000);
            chk("taken", {31'h0, rows[k].br}, {31'h0, got_br});
            if (rows[k].br) begin
                chk("target", 32'h1004 + rows[k].off, got_tgt);
            end
            chk("flag kept", {31'h0, rows[k].t}, {31'h0, o_t_flag});
        end
        // Delayed taken: slot instruction runs, then redirect
        {i_disp, i_disp_sext, i_size} = {8'h04, 1'b0, 2'h0};
        issue(OP_CLRT, 32'h0);
        issue(OP_BFS, 32'h0000_0100);
        chk("no early redirect", 32'h0, {31'h0, got_br});
        issue(OP_ALU, 32'h0000_0104);
        chk("slot redirect", 32'h1, {31'h0, got_br});
        chk("slot target", 32'h0000_0108, got_tgt);
        // Delayed not taken: the slot ends without redirect
        issue(OP_BTS, 32'h0000_0200);
        issue(OP_ALU, 32'h0000_0204);
        chk("bts untaken", 32'h0, {31'h0, got_br});
        // Subroutine call then return to the saved point
        issue(OP_BSR, 32'h0000_0300);
        issue(OP_RTS, 32'h0000_0400);
        chk("return target", 32'h0000_0304, got_tgt);
        chk("return taken", 32'h1, {31'h0, got_br});
        // Exception entry with flag 1, flag cleared inside, then return
        issue(OP_SETT, 32'h0);
        i_exc_pc = 32'h0000_0800;
        i_exc_enter = 1'b1;
        @(negedge i_core_clk);
        i_exc_enter = 1'b0;
        chk("in handler", 32'h1, {31'h0, o_in_exc});
        issue(OP_CLRT, 32'h0);
        issue(OP_RTE, 32'h0000_0900);
        chk("exc return", 32'h0000_0800, got_tgt);
        chk("left handler", 32'h0, {31'h0, o_in_exc});
        chk("flag restored", 32'h1, {31'h0, o_t_flag});
        // Control registers: plain one and the status word
        {i_creg_sel, i_wdata} = {2'h1, 32'h1234_5678};
        issue(OP_LDC, 32'h0);
        issue(OP_STC, 32'h0);
        chk("creg1 read", 32'h1234_5678, got_res);
        chk("result pulse", 32'h1, {31'h0, got_rv});
        {i_creg_sel, i_wdata} = {2'h0, 32'h0000_00a0};
        issue(OP_LDC, 32'h0);
        chk("status flag", 32'h0, {31'h0, o_t_flag});
        issue(OP_SETT, 32'h0);
        issue(OP_STC, 32'h0);
        chk("status read", 32'h0000_00a1, got_res);
        // Flag writes by ordinary instructions
        issue(OP_ALU, 32'h0);
        chk("alu no write", 32'h1, {31'h0, o_t_flag});
        {i_t_wr, i_t_new} = 2'b10;
        issue(OP_ALU, 32'h0);
        chk("alu write", 32'h0, {31'h0, o_t_flag});
        // Added states: load-use, independent, contention, both
        i_dst = 4'h5;
        issue(OP_LOAD, 32'h0);
        {i_src_a, i_src_a_use} = {4'h5, 1'b1};
        issue(OP_ALU, 32'h0);
        chk("load use", 32'h1, stalls);
        issue(OP_LOAD, 32'h0);
        {i_src_a, i_src_a_use} = {4'h5, 1'b0};
        {i_src_b, i_src_b_use} = {4'h6, 1'b1};
        issue(OP_ALU, 32'h0);
        chk("no dependency", 32'h0, stalls);
        {i_data_access, i_fetch_busy} = 2'b11;
        issue(OP_ALU, 32'h0);
        chk("contention", 32'h1, stalls);
        issue(OP_LOAD, 32'h0);
        {i_src_b, i_src_b_use, i_data_access, i_fetch_busy} = 7'b0101_111;
        issue(OP_ALU, 32'h0);
        chk("both added", 32'h2, stalls);
        // Power-down and wake
        i_op = OP_SLEEP;
        i_valid = 1'b1;
        @(negedge i_core_clk);
        i_valid = 1'b0;
        repeat (3) @(negedge i_core_clk);
        chk("asleep", 32'h1, {31'h0, o_sleep});
        chk("not ready asleep", 32'h0, {31'h0, o_ready});
        i_wake = 1'b1;
        @(negedge i_core_clk);
        i_wake = 1'b0;
        chk("awake", 32'h2, {30'h0, o_ready, o_sleep});
        // Mid-run reset with flag set
        issue(OP_SETT, 32'h0);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        chk("rereset flag", 32'h0, {31'h0, o_t_flag});
        chk("rereset ready", 32'h1, {31'h0, o_ready});
        close_out();
    end
endmodule
